// [rtl/dtx_params.svh]
// Constants of the data transfer decoder: fields, codes, reset values
`ifndef DTX_PARAMS_SVH
`define DTX_PARAMS_SVH

// Instruction field positions
`define DTX_OP_HI 15
`define DTX_OP_LO 12
`define DTX_DST_HI 11
`define DTX_DST_LO 8
`define DTX_SRC_HI 7
`define DTX_SRC_LO 4

// Major opcode groups (top nibble)
`define DTX_GRP_INDEX 4'h0
`define DTX_GRP_STLD 4'h1
`define DTX_GRP_IND_ST 4'h2
`define DTX_GRP_SYS 4'h4
`define DTX_GRP_LDLD 4'h5
`define DTX_GRP_IND_LD 4'h6
`define DTX_GRP_R0DSP 4'h8
`define DTX_GRP_PCW 4'h9
`define DTX_GRP_PCL 4'hd
`define DTX_GRP_IMM 4'he

// Low nibble codes
`define DTX_LO_MOVREG 4'h3

// System control codes (full word or low byte with register nibble)
`define DTX_CODE_CLRT 16'h0008
`define DTX_CODE_SETT 16'h0018
`define DTX_CODE_SLEEP 16'h001b
`define DTX_CODE_EXC_RET 16'h002b
`define DTX_LO8_LOOP_START 8'hdc
`define DTX_LO8_LOOP_END 8'hec
`define DTX_LO8_LOOP_COUNT 8'h14

// Status register bit positions
`define DTX_STAT_T 0
`define DTX_STAT_Q 8
`define DTX_STAT_M 9

// Reset values
`define DTX_STAT_RST 32'h0000_0000
`define DTX_GPR_RST 32'h0000_0000

// Minimum execution cycles with no wait states
`define DTX_MIN_CYCLES 1

`endif

// [rtl/dtx_pkg.sv]
// Types shared by the data transfer decoder modules
package dtx_pkg;

  typedef enum logic [1:0] {
    DTX_SZ_BYTE = 2'h0,
    DTX_SZ_WORD = 2'h1,
    DTX_SZ_LONG = 2'h2
  } dtx_size_e;

  typedef enum logic [3:0] {
    DTX_ST_RUN = 4'h1,
    DTX_ST_MEM = 4'h2,
    DTX_ST_LWB = 4'h4,
    DTX_ST_SLEEP = 4'h8
  } dtx_state_e;

  typedef logic [31:0] dtx_word_t;

endpackage

// [rtl/dtx_dec_if.sv]
// Decoder hand-off between the core and its address generator
`timescale 1ns/1ps
interface dtx_dec_if;
  import dtx_pkg::*;
  logic [15:0] insn;
  dtx_word_t pc;
  dtx_word_t src_val;
  dtx_word_t dst_val;
  dtx_word_t zero_val;
  logic mem;
  logic load;
  dtx_size_e size;
  dtx_word_t addr;
  dtx_word_t wdata;
  logic [3:0] ld_dst;
  logic alu_we;
  logic [3:0] alu_dst;
  dtx_word_t alu_val;
  logic upd_we;
  logic [3:0] upd_dst;
  dtx_word_t upd_val;
  logic misaligned;

  modport dec (
    input insn, pc, src_val, dst_val, zero_val,
    output mem, load, size, addr, wdata, ld_dst, alu_we, alu_dst, alu_val,
    output upd_we, upd_dst, upd_val, misaligned
  );
  modport core (
    output insn, pc, src_val, dst_val, zero_val,
    input mem, load, size, addr, wdata, ld_dst, alu_we, alu_dst, alu_val,
    input upd_we, upd_dst, upd_val, misaligned
  );
endinterface

// [rtl/dtx_ext.sv]
// Sign extension of loaded bytes and words
`timescale 1ns/1ps
module dtx_ext
  import dtx_pkg::*;
(
  input wire dtx_size_e size,
  input wire dtx_word_t raw,
  output dtx_word_t ext
);
  // Byte and word results are sign-extended, longwords pass unchanged
  always_comb begin
    case (size)
      DTX_SZ_BYTE: ext = {{24{raw[7]}}, raw[7:0]};
      DTX_SZ_WORD: ext = {{16{raw[15]}}, raw[15:0]};
      default: ext = raw;
    endcase
  end
endmodule

// [rtl/dtx_decode.sv]
// Address generation and operand selection for data transfer codes
`timescale 1ns/1ps
`include "dtx_params.svh"
module dtx_decode
  import dtx_pkg::*;
(
  dtx_dec_if.dec d
);
  logic [3:0] grp;
  logic [3:0] lo;
  logic [3:0] n;
  dtx_word_t disp4;
  dtx_word_t disp8;
  dtx_size_e sz;

  // Displacement is scaled by the operand size
  function automatic dtx_word_t scale(input dtx_word_t v, input dtx_size_e s);
    scale = v << s;
  endfunction

  // Byte count of an operand size
  function automatic dtx_word_t step(input dtx_size_e s);
    step = 32'h1 << s;
  endfunction

  assign grp = d.insn[`DTX_OP_HI:`DTX_OP_LO];
  assign lo = d.insn[3:0];
  assign n = d.insn[`DTX_DST_HI:`DTX_DST_LO];
  assign disp4 = {28'h0, d.insn[3:0]};
  assign disp8 = {24'h0, d.insn[7:0]};
  assign sz = dtx_size_e'(lo[1:0]);

  // Field decode, most significant nibble first
  always_comb begin
    d.mem = 1'b0;
    d.load = 1'b0;
    d.size = DTX_SZ_LONG;
    d.addr = 32'h0;
    d.wdata = d.src_val;
    d.ld_dst = n;
    d.alu_we = 1'b0;
    d.alu_dst = n;
    d.alu_val = 32'h0;
    d.upd_we = 1'b0;
    d.upd_dst = n;
    d.upd_val = 32'h0;
    case (grp)
      `DTX_GRP_IMM: begin
        d.alu_we = 1'b1;
        d.alu_val = {{24{d.insn[7]}}, d.insn[7:0]};
      end
      `DTX_GRP_PCW: begin
        d.mem = 1'b1;
        d.load = 1'b1;
        d.size = DTX_SZ_WORD;
        d.addr = scale(disp8, DTX_SZ_WORD) + d.pc;
      end
      `DTX_GRP_PCL: begin
        d.mem = 1'b1;
        d.load = 1'b1;
        d.addr = scale(disp8, DTX_SZ_LONG) + {d.pc[31:2], 2'h0};
      end
      `DTX_GRP_IND_LD: begin
        if (lo == `DTX_LO_MOVREG) begin
          d.alu_we = 1'b1;
          d.alu_val = d.src_val;
        end else if (lo[3] == 1'b0 && lo[1:0] != 2'h3) begin
          d.mem = 1'b1;
          d.load = 1'b1;
          d.size = sz;
          d.addr = d.src_val;
          d.upd_we = lo[2];
          d.upd_dst = d.insn[`DTX_SRC_HI:`DTX_SRC_LO];
          d.upd_val = d.src_val + step(sz);
        end
      end
      `DTX_GRP_IND_ST: begin
        if (lo[3] == 1'b0 && lo[1:0] != 2'h3) begin
          d.mem = 1'b1;
          d.size = sz;
          d.upd_we = lo[2];
          d.upd_val = d.dst_val - step(sz);
          // Pre-decrement writes to the already lowered address
          d.addr = lo[2] ? d.upd_val : d.dst_val;
        end
      end
      `DTX_GRP_R0DSP: begin
        if (d.insn[11:10] == 2'h0 && d.insn[9:8] != 2'h3 && d.insn[9:8] != 2'h2) begin
          d.mem = 1'b1;
          d.size = dtx_size_e'(d.insn[9:8]);
          // The base sits in the second nibble here; the first is part of the opcode
          d.addr = scale(disp4, d.size) + d.src_val;
          d.wdata = d.zero_val;
          d.ld_dst = 4'h0;
        end else if (d.insn[11:10] == 2'h1 && d.insn[9:8] != 2'h3 && d.insn[9:8] != 2'h2) begin
          d.mem = 1'b1;
          d.load = 1'b1;
          d.size = dtx_size_e'(d.insn[9:8]);
          d.addr = scale(disp4, d.size) + d.src_val;
          d.ld_dst = 4'h0;
        end
      end
      `DTX_GRP_STLD: begin
        d.mem = 1'b1;
        d.addr = scale(disp4, DTX_SZ_LONG) + d.dst_val;
      end
      `DTX_GRP_LDLD: begin
        d.mem = 1'b1;
        d.load = 1'b1;
        d.addr = scale(disp4, DTX_SZ_LONG) + d.src_val;
      end
      `DTX_GRP_INDEX: begin
        if (lo[1:0] != 2'h3 && lo[1:0] != 2'h2 || lo[3:0] == 4'h6 || lo[3:0] == 4'he) begin
          if (lo[3:2] == 2'h1) begin
            d.mem = 1'b1;
            d.size = sz;
            d.addr = d.zero_val + d.dst_val;
          end else if (lo[3:2] == 2'h3) begin
            d.mem = 1'b1;
            d.load = 1'b1;
            d.size = sz;
            d.addr = d.zero_val + d.src_val;
          end
        end
      end
      default: begin
        d.mem = 1'b0;
      end
    endcase
  end

  // Word and longword accesses must sit on their natural boundary
  assign d.misaligned = d.mem && ((d.size == DTX_SZ_WORD && d.addr[0]) ||
                                  (d.size == DTX_SZ_LONG && d.addr[1:0] != 2'h0));
endmodule

// [rtl/dtx_core.sv]
// Data transfer execution core: register file, bus sequencing, control ops
//
// Overview of operation
// - Cycle counts are minimums; waits may extend.
// - Stall when fetch and data access contend.
// - Stall next instruction using a just-loaded register.
// - Scale displacement by one, two or four.
// - Decode MSB first; nibbles select registers 0-15.
// - Status register holds M, Q and T.
// - Immediate move sign-extends eight bits, one cycle.
// - PC word load at disp*2+PC, sign-extended.
// - Indirect loads sign-extend bytes and words.
// - Post-increment adds operand size after load.
// - Pre-decrement subtracts size, then stores there.
// - Byte store of zero register, unscaled displacement.
// - Word store of zero register, displacement times two.
// - Long displacement store, displacement times four.
// - Byte displacement load into zero register.
// - Word displacement load into zero register.
// - Long displacement load into any register.
// - Indexed stores at zero register plus base.
// - Indexed loads at zero register plus source.
// - Loop start, end and count setting ops.
// - Sleep op enters power-down state.
// - Exception return op ends exception handling; here it only pulses exc_return.
`timescale 1ns/1ps
`include "dtx_params.svh"
module dtx_core
  import dtx_pkg::*;
#(
  parameter int REGS = 16,
  parameter int COUNT_W = 12
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] insn,
  input wire logic insn_valid,
  output logic insn_ready,
  input wire dtx_word_t pc,
  input wire logic fetch_busy,
  input wire logic wake,
  output logic bus_req,
  output logic bus_we,
  output dtx_size_e bus_size,
  output dtx_word_t bus_addr,
  output dtx_word_t bus_wdata,
  input wire dtx_word_t bus_rdata,
  input wire logic bus_ack,
  output logic addr_err,
  output logic exc_return,
  output logic sleeping,
  output dtx_word_t status_reg,
  output dtx_word_t loop_start,
  output dtx_word_t loop_end,
  output logic [COUNT_W-1:0] loop_count
);
  dtx_dec_if dec_bus ();
  dtx_state_e state;
  dtx_word_t gpr [REGS];
  dtx_word_t ld_data;
  dtx_word_t ld_ext;
  logic [3:0] ld_dst;
  logic ld_pend;
  logic upd_we;
  logic [3:0] upd_dst;
  dtx_word_t upd_val;
  logic take;
  logic is_sys;
  logic [7:0] sys_lo;
  logic hazard;

  // True when the code names a register through either nibble or implies the zero register
  function automatic logic reads_reg(input logic [15:0] c, input logic [3:0] r);
    logic implied_zero;
    implied_zero = (c[15:12] == `DTX_GRP_INDEX) || (c[15:12] == `DTX_GRP_R0DSP);
    reads_reg = (c[11:8] == r) || (c[7:4] == r) || (implied_zero && r == 4'h0);
  endfunction

  // Register file read ports into the decoder
  assign dec_bus.insn = insn;
  assign dec_bus.pc = pc;
  // Three read ports: both nibbles plus the implied zero register.
  // Reads are combinational so a code taken in write-back sees settled values.
  assign dec_bus.dst_val = gpr[insn[`DTX_DST_HI:`DTX_DST_LO]];
  assign dec_bus.src_val = gpr[insn[`DTX_SRC_HI:`DTX_SRC_LO]];
  assign dec_bus.zero_val = gpr[0];

  // The decoder is purely combinational; its outputs matter only on an
  // accepting edge, so glitches while a code is offered are harmless.
  // Keeping it apart lets the address adders be timed on their own.
  dtx_decode u_decode (
    .d(dec_bus.dec)
  );

  dtx_ext u_ext (
    .size(bus_size),
    .raw(bus_rdata),
    .ext(ld_ext)
  );

  // Loop set-up codes share one group and differ in the low byte
  assign sys_lo = insn[7:0];
  assign is_sys = (insn[15:12] == `DTX_GRP_SYS) &&
                  (sys_lo == `DTX_LO8_LOOP_START || sys_lo == `DTX_LO8_LOOP_END ||
                   sys_lo == `DTX_LO8_LOOP_COUNT);

  // The hazard test is deliberately coarse: it compares both nibbles even
  // where the low byte is a displacement or an immediate. That costs an
  // occasional needless stall but never lets a code read a stale register.
  // A code that only writes the loaded register stalls too, so the later
  // writer always wins.
  assign hazard = (state == DTX_ST_LWB) && reads_reg(insn, ld_dst);

  // Accept while running, or during the load write-back if there is no hazard.
  // A memory code waits while the fetch owns the bus, costing a cycle but never a slot.
  always_comb begin
    insn_ready = 1'b0;
    if (state == DTX_ST_RUN || (state == DTX_ST_LWB && !hazard)) begin
      insn_ready = !(dec_bus.mem && fetch_busy);
    end
  end
  assign take = insn_valid && insn_ready;

  // Sequencer: run, wait for the bus, write back a load, or sleep.
  //
  // Timing of a load, edge by edge:
  //   c0   code taken; request and the pending base update are latched
  //   c1   request stands with its address, size and direction
  //   cK   partner acknowledges; the base update lands at this edge
  //   cK+1 write-back cycle; the result enters the register file at its end
  // A store ends at cK and goes straight back to run. Only one access is
  // ever outstanding, so no queue or tag is needed on the data bus.
  //
  // The write-back cycle still accepts a new code, which keeps a run of
  // independent loads close to one per access. The price is the hazard
  // test above: a code that names the loaded register waits one cycle.
  // Sleep is left only through wake; no code is accepted meanwhile.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= DTX_ST_RUN;
    end else begin
      case (state)
        DTX_ST_RUN, DTX_ST_LWB: begin
          if (take && insn == `DTX_CODE_SLEEP) begin
            state <= DTX_ST_SLEEP;
          end else if (take && dec_bus.mem && !dec_bus.misaligned) begin
            state <= DTX_ST_MEM;
          end else begin
            state <= DTX_ST_RUN;
          end
        end
        DTX_ST_MEM: begin
          // Wait states only lengthen the access
          if (bus_ack) begin
            state <= ld_pend ? DTX_ST_LWB : DTX_ST_RUN;
          end
        end
        DTX_ST_SLEEP: begin
          if (wake) begin
            state <= DTX_ST_RUN;
          end
        end
        default: state <= DTX_ST_RUN;
      endcase
    end
  end

  // Bus request stands from the cycle after acceptance until acknowledged.
  // Address, size, direction and data stay put after the acknowledge too;
  // the partner must qualify them with the request, never on their own.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_size <= DTX_SZ_LONG;
      bus_addr <= 32'h0;
      bus_wdata <= 32'h0;
    end else if (take && dec_bus.mem && !dec_bus.misaligned) begin
      bus_req <= 1'b1;
      bus_we <= !dec_bus.load;
      bus_size <= dec_bus.size;
      bus_addr <= dec_bus.addr;
      bus_wdata <= dec_bus.wdata;
    end else if (bus_ack) begin
      bus_req <= 1'b0;
    end
  end

  // Pending load and base-register update, held across wait states.
  // Load data is extended on the way in so write-back is a plain copy.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ld_pend <= 1'b0;
      ld_dst <= 4'h0;
      upd_we <= 1'b0;
      upd_dst <= 4'h0;
      upd_val <= 32'h0;
      ld_data <= 32'h0;
    end else begin
      if (take && dec_bus.mem && !dec_bus.misaligned) begin
        ld_pend <= dec_bus.load;
        ld_dst <= dec_bus.ld_dst;
        upd_we <= dec_bus.upd_we;
        upd_dst <= dec_bus.upd_dst;
        upd_val <= dec_bus.upd_val;
      end
      if (state == DTX_ST_MEM && bus_ack) begin
        ld_data <= ld_ext;
      end
    end
  end

  // Misaligned accesses are dropped and flagged for one cycle.
  // Nothing else records them: the exception logic outside must act on
  // the pulse itself, and no register or base update is applied.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_err <= 1'b0;
    end else begin
      addr_err <= take && dec_bus.misaligned;
    end
  end

  // Register file writes; a load result overrides a same-register update.
  // The three write sources never fall on one register in one cycle: the update
  // lands a cycle before the load, and the hazard stall keeps immediates away.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < REGS; i++) begin
        gpr[i] <= `DTX_GPR_RST;
      end
    end else begin
      if (take && dec_bus.alu_we) begin
        gpr[dec_bus.alu_dst] <= dec_bus.alu_val;
      end
      if (state == DTX_ST_MEM && bus_ack && upd_we) begin
        gpr[upd_dst] <= upd_val;
      end
      if (state == DTX_ST_LWB) begin
        gpr[ld_dst] <= ld_data;
      end
    end
  end

  // Status flags: transfers leave them alone, only T set and clear touch T.
  // Q and M have their places here for the division steps, which live in
  // another block; nothing in this one writes them.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_reg <= `DTX_STAT_RST;
    end else if (take && insn == `DTX_CODE_SETT) begin
      status_reg[`DTX_STAT_T] <= 1'b1;
    end else if (take && insn == `DTX_CODE_CLRT) begin
      status_reg[`DTX_STAT_T] <= 1'b0;
    end
  end

  // Hardware loop registers loaded from the named register.
  // Only the low COUNT_W bits of a count are kept; larger values wrap.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      loop_start <= 32'h0;
      loop_end <= 32'h0;
      loop_count <= '0;
    end else if (take && is_sys) begin
      if (sys_lo == `DTX_LO8_LOOP_START) begin
        loop_start <= dec_bus.dst_val;
      end else if (sys_lo == `DTX_LO8_LOOP_END) begin
        loop_end <= dec_bus.dst_val;
      end else begin
        loop_count <= dec_bus.dst_val[COUNT_W-1:0];
      end
    end
  end

  // Exception return is signalled to the sequencing logic outside.
  // Restoring the saved state and the jump back are not done here.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exc_return <= 1'b0;
    end else begin
      exc_return <= take && insn == `DTX_CODE_EXC_RET;
    end
  end

  assign sleeping = (state == DTX_ST_SLEEP);
endmodule

// [dv/dtx_core_properties.sv]
// Port timing checks for the data transfer core
`timescale 1ns/1ps
module dtx_core_properties
  import dtx_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] insn,
  input wire logic insn_valid,
  input wire logic insn_ready,
  input wire logic fetch_busy,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire dtx_size_e bus_size,
  input wire dtx_word_t bus_addr,
  input wire logic bus_ack,
  input wire logic addr_err,
  input wire logic exc_return,
  input wire logic sleeping,
  input wire dtx_word_t status_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic take;
  logic mem_code;
  // Memory forms by group; groups 0, 2, 6 and 8 also hold register-only codes
  always_comb begin
    take = insn_valid && insn_ready;
    case (insn[15:12])
      4'h0: mem_code = insn[2] && insn[1:0] != 2'h3;
      4'h2, 4'h6: mem_code = !insn[3] && insn[1:0] != 2'h3;
      4'h8: mem_code = !insn[11] && !insn[9];
      4'h1, 4'h5, 4'h9, 4'hd: mem_code = 1'b1;
      default: mem_code = 1'b0;
    endcase
  end
  sequence s_take_mem;
    take && mem_code;
  endsequence
  sequence s_wait_ack;
    bus_req ##[0:8] bus_ack;
  endsequence
  property p_issue_or_refuse;
    s_take_mem |=> bus_req != addr_err;
  endproperty
  a_issue_or_refuse: assert property (p_issue_or_refuse) else $error("memory code lost");
  property p_ack_in_time;
    s_take_mem ##1 bus_req |-> s_wait_ack;
  endproperty
  a_ack_in_time: assert property (p_ack_in_time) else $error("access never acknowledged");
  property p_req_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_size);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop;
    bus_ack |=> !bus_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_err_clean;
    addr_err |-> !bus_req;
  endproperty
  a_err_clean: assert property (p_err_clean) else $error("refused access reached bus");
  property p_fetch_stall;
    fetch_busy && mem_code |-> !insn_ready;
  endproperty
  a_fetch_stall: assert property (p_fetch_stall) else $error("memory code taken in fetch");
  property p_imm;
    take && insn[15:12] == 4'he |=> !bus_req && !addr_err && $stable(status_reg);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate move touched bus or flags");
  property p_mem_keeps_t;
    s_take_mem |=> $stable(status_reg[0]);
  endproperty
  a_mem_keeps_t: assert property (p_mem_keeps_t) else $error("transfer changed T");
  property p_t_ops;
    take && (insn == 16'h0008 || insn == 16'h0018) |=> status_reg[0] == $past(insn[4]);
  endproperty
  a_t_ops: assert property (p_t_ops) else $error("T flag op wrong");
  property p_rte;
    take && insn == 16'h002b |=> exc_return ##1 !exc_return;
  endproperty
  a_rte: assert property (p_rte) else $error("exception return pulse wrong");
  property p_sleep;
    take && insn == 16'h001b |=> sleeping && !insn_ready;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
endmodule
bind dtx_core dtx_core_properties u_props (.mclk, .sys_rst, .insn, .insn_valid, .insn_ready,
  .fetch_busy, .bus_req, .bus_we, .bus_size, .bus_addr, .bus_ack, .addr_err, .exc_return,
  .sleeping, .status_reg);

// [dv/dtx_mem_model.sv]
// Data bus responder with random wait states and scrambled idle read data
`timescale 1ns/1ps
module dtx_mem_model
  import dtx_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bus_req,
  input wire dtx_word_t bus_addr,
  output dtx_word_t bus_rdata,
  output logic bus_ack
);
  int wait_left;
  // Ack after 0..3 waits; data is only meaningful in the ack cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0;
      wait_left <= 0;
    end else if (bus_ack || !bus_req) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_left <= $urandom_range(3);
    end else if (wait_left == 0) begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr * 32'h9e3779b1 ^ 32'h5a3c0f96; // Upper bits are noise
    end else begin
      wait_left <= wait_left - 1;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule

// [dv/data_transfer_insn_decode_tb_top.sv]
// Self-checking bench for the data transfer core against a register model
`timescale 1ns/1ps
module data_transfer_insn_decode_tb_top;
  import dtx_pkg::*;
  typedef struct {logic err; logic we; logic [1:0] sz; dtx_word_t a; dtx_word_t d;} dtx_acc_s;
  logic mclk = 1'b0;
  logic sys_rst, insn_valid, insn_ready, fetch_busy, wake, bus_req, bus_we, bus_ack;
  logic addr_err, exc_return, sleeping, ok;
  logic [15:0] insn;
  logic [11:0] loop_count;
  logic [3:0] n, mm, d;
  logic [7:0] d8;
  logic [1:0] sz;
  dtx_size_e bus_size;
  dtx_word_t pc, pcv, sb, bus_addr, bus_wdata, bus_rdata, status_reg, loop_start, loop_end;
  dtx_word_t m [16];
  dtx_acc_s exp_q [$];
  dtx_acc_s e;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 mclk = ~mclk;
  dtx_core dut (.mclk, .sys_rst, .insn, .insn_valid, .insn_ready, .pc, .fetch_busy, .wake,
    .bus_req, .bus_we, .bus_size, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .addr_err,
    .exc_return, .sleeping, .status_reg, .loop_start, .loop_end, .loop_count);
  dtx_mem_model u_mem (.mclk, .sys_rst, .bus_req, .bus_addr, .bus_rdata, .bus_ack);
  function automatic dtx_word_t sx(input dtx_word_t v, input logic [1:0] s);
    return s == 2'h0 ? {{24{v[7]}}, v[7:0]} : s == 2'h1 ? {{16{v[15]}}, v[15:0]} : v;
  endfunction
  function automatic dtx_word_t msk(input logic we, input logic [1:0] s);
    return !we ? 32'h0 : s == 2'h0 ? 32'hff : s == 2'h1 ? 32'hffff : 32'hffffffff;
  endfunction
  task automatic chk(input string nm, input logic [66:0] ex, input logic [66:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    fetch_busy <= $urandom_range(3) == 0;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  // Each acknowledged access or refusal is matched to the oldest expectation
  always @(negedge mclk) begin
    if (!sys_rst && ((bus_req && bus_ack) || addr_err)) begin
      if (exp_q.size() == 0) chk("spare access", 1, 0);
      else begin
        e = exp_q.pop_front();
        chk("refusal", e.err, addr_err);
        if (!e.err) chk("access", {e.we, e.sz, e.a, e.d},
          {bus_we, bus_size, bus_addr, bus_wdata & msk(e.we, e.sz)});
      end
    end
  end
  // Offer a code at this edge and return at the edge that takes it
  task automatic issue(input logic [15:0] c);
    insn <= c;
    insn_valid <= 1'b1;
    @(negedge mclk);
    while (insn_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  task automatic imm(input logic [3:0] r, input logic [7:0] v);
    m[r] = sx({24'h0, v}, 2'h0);
    issue({4'he, r, v});
  endtask
  // Model one access: misaligned ones change nothing, updates land before the load
  task automatic mem_op(input logic [15:0] c, input logic we, input logic [1:0] s,
                        input dtx_word_t a, input dtx_word_t dv, input int dst,
                        input int upd, input dtx_word_t uv);
    ok = (a & ((32'h1 << s) - 32'h1)) == 32'h0;
    exp_q.push_back('{!ok, we, s, a, dv & msk(we, s)});
    if (ok && upd >= 0) m[upd] = uv;
    if (ok && !we) m[dst] = sx(a * 32'h9e3779b1 ^ 32'h5a3c0f96, s);
    issue(c);
  endtask
  // Spill every register through long displacement stores off an aligned base
  task automatic dump;
    imm(4'hf, {6'($urandom), 2'h0});
    for (int r = 0; r < 16; r++) begin
      d = 4'($urandom);
      mem_op({4'h1, 4'hf, 4'(r), d}, 1, 2, m[15] + {d, 2'h0}, m[r], 0, -1, 0);
    end
  endtask
  initial begin
    void'($urandom(24));
    {sys_rst, insn_valid, wake, insn, pc} = {3'b100, 16'h0, 32'h0};
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk("reset status", 0, status_reg);
    @(posedge mclk);
    issue(16'h0008);
    issue(16'h0018);
    for (int r = 0; r < 16; r++) imm(4'(r), 8'($urandom));
    dump();
    for (int i = 0; i < 150; i++) begin
      {n, mm, d, d8} = 20'($urandom);
      sz = 2'($urandom_range(2));
      sb = 32'h1 << sz;
      pcv = $urandom & 32'hfffffffe;
      pc <= pcv;
      case ($urandom_range(9))
        0: mem_op({4'h2, n, mm, 2'h0, sz}, 1, sz, m[n], m[mm], 0, -1, 0);
        1: begin
          if (n == mm) n = mm + 4'h1;
          mem_op({4'h2, n, mm, 2'h1, sz}, 1, sz, m[n] - sb, m[mm], 0, n, m[n] - sb);
        end
        2: mem_op({4'h6, n, mm, 2'h0, sz}, 0, sz, m[mm], 0, n, -1, 0);
        3: mem_op({4'h6, n, mm, 2'h1, sz}, 0, sz, m[mm], 0, n, mm, m[mm] + sb);
        4: if (sz == 2'h2) mem_op({4'h1, n, mm, d}, 1, 2, m[n] + {d, 2'h0}, m[mm], 0, -1, 0);
          else mem_op({7'h40, sz[0], n, d}, 1, sz, m[n] + (32'(d) << sz), m[0], 0, -1, 0);
        5: if (sz == 2'h2) mem_op({4'h5, n, mm, d}, 0, 2, m[mm] + {d, 2'h0}, 0, n, -1, 0);
          else mem_op({7'h42, sz[0], mm, d}, 0, sz, m[mm] + (32'(d) << sz), 0, 0, -1, 0);
        6: mem_op({4'h0, n, mm, 2'h1, sz}, 1, sz, m[0] + m[n], m[mm], 0, -1, 0);
        7: mem_op({4'h0, n, mm, 2'h3, sz}, 0, sz, m[0] + m[mm], 0, n, -1, 0);
        8: if (sz[1]) mem_op({4'hd, n, d8}, 0, 2, (pcv & ~32'h3) + {d8, 2'h0}, 0, n, -1, 0);
          else mem_op({4'h9, n, d8}, 0, 1, pcv + {d8, 1'b0}, 0, n, -1, 0);
        default: imm(n, d8);
      endcase
    end
    dump();
    n = 4'($urandom);
    issue({4'h4, n, 8'hdc});
    issue({4'h4, n, 8'hec});
    issue({4'h4, n, 8'h14});
    issue(16'h002b);
    insn_valid <= 1'b0;
    @(negedge mclk);
    chk("exc return", 1, exc_return);
    @(posedge mclk);
    issue(16'h001b);
    insn_valid <= 1'b0;
    wait (exp_q.size() == 0);
    repeat (3) @(negedge mclk);
    chk("sleeping", 1, sleeping);
    chk("loop start", m[n], loop_start);
    chk("loop end", m[n], loop_end);
    chk("loop count", m[n][11:0], loop_count);
    chk("status", 32'h1, status_reg);
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("awake", 0, sleeping);
    tally_and_finish();
  end
endmodule
